// ===== testbench/sslch_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module sslch_master_model (
    input wire logic core_clk,
    input wire logic loop_en,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic corrupt,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end

    // Test wiring: each sent byte comes back one cycle later
    always @(posedge core_clk) begin
        rx_valid <= tx_valid && loop_en;
        // Idle line toggles, so a stale byte never looks valid
        rx_byte <= tx_valid ? (corrupt ? ~tx_byte : tx_byte) : ~rx_byte;
    end
endmodule : sslch_master_model

`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sslch_defines.svh"

module tb_top;
    int errors;
    int comparisons;
    logic core_clk, nrst, req_valid, corrupt, rx_valid, resp_valid, resp_exception;
    logic stage_we, commit_ram, commit_nv, loop_en, tx_valid, diag_pass, comm_error_alarm, error_contact, op_ready;
    logic [8:0] fl;
    logic [7:0] own_addr, req_slave, req_func, req_bytes, strap, rx_byte, tx_byte, resp_code;
    logic [15:0] req_addr, req_qty, req_word0, req_word1, local_op, op_signal, freq_ref, stage_addr, stage_data;
    logic [15:0] rd_addr [3];

    sslch_core #(.DIAG_TIMEOUT_CYC(20)) sslch_core_i (
        .core_clk(core_clk), .nrst(nrst), .own_addr(own_addr), .req_valid(req_valid),
        .req_comm_err(fl[0]), .req_gap_err(fl[1]), .req_len_err(fl[2]), .req_slave(req_slave),
        .req_func(req_func), .req_addr(req_addr), .req_qty(req_qty), .req_bytes(req_bytes),
        .req_word0(req_word0), .req_word1(req_word1), .param_limit_err(fl[3]), .param_permitted(!fl[8]),
        .param_busy(fl[7]), .running(fl[4]), .main_undervoltage_alarm(fl[5]), .nonvolatile_fault_warning(fl[6]),
        .local_op(local_op), .input_five_function_select(strap), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .resp_valid(resp_valid), .resp_exception(resp_exception), .resp_code(resp_code),
        .op_signal(op_signal), .freq_ref(freq_ref), .stage_we(stage_we), .stage_addr(stage_addr),
        .stage_data(stage_data), .commit_ram(commit_ram), .commit_nv(commit_nv), .loop_en(loop_en),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .diag_pass(diag_pass), .comm_error_alarm(comm_error_alarm),
        .error_contact(error_contact), .op_ready(op_ready)
    );

    sslch_master_model sslch_master_model_i (
        .core_clk(core_clk), .loop_en(loop_en), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .corrupt(corrupt), .rx_valid(rx_valid), .rx_byte(rx_byte)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // Expected outcome bits: reply, staging write, RAM commit, NV commit
    task automatic req(input logic [8:0] f, input logic [7:0] sl, input logic [7:0] fn, input logic [15:0] ad,
        input logic [15:0] q, input logic [7:0] by, input logic [15:0] w0, input logic [15:0] w1,
        input logic [3:0] exp, input logic [7:0] code);
        @(negedge core_clk);
        {fl, req_slave, req_func, req_addr, req_qty, req_bytes, req_word0, req_word1} = {f, sl, fn, ad, q, by, w0, w1};
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        fl = 9'h000;
        cmp("outcome", exp, {resp_valid, stage_we, commit_ram, commit_nv});
        if (exp[3]) begin
            cmp("resp_exception", code != 8'h00, resp_exception);
            cmp("resp_code", code, resp_code);
        end
    endtask : req

    // Power-up with a given strap; outcome is pass, alarm, error contact
    task automatic boot(input logic [7:0] s, input logic c, input logic [2:0] exp);
        int n;
        @(negedge core_clk);
        nrst = 1'b0;
        strap = s;
        corrupt = c;
        repeat (4) @(negedge core_clk);
        nrst = 1'b1;
        n = 0;
        while (!(diag_pass === 1'b1 || comm_error_alarm === 1'b1 || op_ready === 1'b1) && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        cmp("diag_outputs", exp, {diag_pass, comm_error_alarm, error_contact});
    endtask : boot

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        comparisons = 0;
        {nrst, req_valid, corrupt, fl, req_slave, req_func, req_addr, req_qty, req_bytes} = '0;
        {req_word0, req_word1} = '0;
        strap = 8'h00;
        own_addr = 8'h05;
        local_op = 16'h0fcc;
        rd_addr = '{16'h0900, 16'h0910, 16'h0a00};

        boot(8'h43, 1'b0, 3'b100);
        boot(8'h43, 1'b1, 3'b011);
        cmp("op_ready", 1'b0, op_ready);
        boot(8'h00, 1'b0, 3'b000);
        cmp("op_ready", 1'b1, op_ready);
        $display("test diagnosis done");

        req(9'h000, 8'h00, 8'h10, 16'h0001, 16'h0002, 8'h04, 16'ha0d1, 16'd30000, 4'b0000, 8'h00);
        repeat (2) @(negedge core_clk);
        cmp("op_signal", (16'ha0d1 & `SSLCH_OP_DEF_MASK) | (local_op & ~`SSLCH_OP_DEF_MASK), op_signal);
        cmp("freq_ref", 16'd30000, freq_ref);
        local_op = 16'h0f30;
        repeat (2) @(negedge core_clk);
        cmp("op_signal", (16'ha0d1 & `SSLCH_OP_DEF_MASK) | (local_op & ~`SSLCH_OP_DEF_MASK), op_signal);
        req(9'h000, 8'h05, 8'h10, 16'h0002, 16'h0001, 8'h02, 16'd30001, 16'h0000, 4'b1000, 8'h21);
        cmp("freq_ref", 16'd30000, freq_ref);
        req(9'h000, 8'h00, 8'h10, 16'h0123, 16'h0001, 8'h02, 16'h0007, 16'h0000, 4'b0000, 8'h00);
        $display("test broadcast done");

        req(9'h000, 8'h05, 8'h10, 16'h0123, 16'h0001, 8'h02, 16'h1234, 16'h0000, 4'b1100, 8'h00);
        cmp("stage_addr", 16'h0123, stage_addr);
        cmp("stage_data", 16'h1234, stage_data);
        req(9'h000, 8'h05, 8'h10, 16'h0910, 16'h0001, 8'h02, 16'h0000, 16'h0000, 4'b1010, 8'h00);
        req(9'h000, 8'h05, 8'h10, 16'h0900, 16'h0001, 8'h02, 16'h0000, 16'h0000, 4'b1001, 8'h00);
        req(9'h000, 8'h05, 8'h10, 16'h0900, 16'h0001, 8'h02, 16'h0001, 16'h0000, 4'b1000, 8'h21);
        $display("test commit done");

        foreach (rd_addr[i]) begin
            req(9'h000, 8'h05, 8'h03, rd_addr[i], 16'h0001, 8'h00, 16'h0000, 16'h0000, 4'b1000, 8'h02);
        end
        req(9'h000, 8'h05, 8'h04, 16'h0001, 16'h0001, 8'h00, 16'h0000, 16'h0000, 4'b1000, 8'h01);
        req(9'h000, 8'h05, 8'h06, 16'h0001, 16'h0001, 8'h00, 16'h0000, 16'h0000, 4'b1000, 8'h01);
        req(9'h000, 8'h05, 8'h03, 16'h0020, 16'h0010, 8'h00, 16'h0000, 16'h0000, 4'b1000, 8'h00);
        req(9'h000, 8'h05, 8'h08, 16'h0000, 16'h0001, 8'h00, 16'h0000, 16'h0000, 4'b1000, 8'h00);
        req(9'h000, 8'h05, 8'h03, 16'h0001, 16'h0000, 8'h00, 16'h0000, 16'h0000, 4'b1000, 8'h03);
        req(9'h000, 8'h05, 8'h03, 16'h0001, 16'h0011, 8'h00, 16'h0000, 16'h0000, 4'b1000, 8'h03);
        req(9'h000, 8'h05, 8'h10, 16'h0123, 16'h0001, 8'h03, 16'h0007, 16'h0000, 4'b1000, 8'h03);
        $display("test decode done");

        req(9'h010, 8'h05, 8'h10, 16'h0123, 16'h0001, 8'h02, 16'h0007, 16'h0000, 4'b1000, 8'h22);
        req(9'h010, 8'h05, 8'h10, 16'h0910, 16'h0001, 8'h02, 16'h0000, 16'h0000, 4'b1000, 8'h22);
        req(9'h000, 8'h05, 8'h10, 16'h0020, 16'h0001, 8'h02, 16'h0007, 16'h0000, 4'b1000, 8'h22);
        req(9'h140, 8'h05, 8'h10, 16'h0123, 16'h0001, 8'h02, 16'h0007, 16'h0000, 4'b1000, 8'h22);
        req(9'h020, 8'h05, 8'h10, 16'h0123, 16'h0001, 8'h02, 16'h0007, 16'h0000, 4'b1000, 8'h23);
        req(9'h020, 8'h05, 8'h10, 16'h0900, 16'h0001, 8'h02, 16'h0000, 16'h0000, 4'b1000, 8'h23);
        req(9'h080, 8'h05, 8'h10, 16'h0123, 16'h0001, 8'h02, 16'h0007, 16'h0000, 4'b1000, 8'h24);
        req(9'h008, 8'h05, 8'h10, 16'h0123, 16'h0001, 8'h02, 16'h0007, 16'h0000, 4'b1000, 8'h21);
        $display("test write errors done");

        req(9'h001, 8'h05, 8'h10, 16'h0910, 16'h0001, 8'h02, 16'h0000, 16'h0000, 4'b0000, 8'h00);
        req(9'h002, 8'h05, 8'h10, 16'h0910, 16'h0001, 8'h02, 16'h0000, 16'h0000, 4'b0000, 8'h00);
        req(9'h004, 8'h05, 8'h10, 16'h0910, 16'h0001, 8'h02, 16'h0000, 16'h0000, 4'b0000, 8'h00);
        req(9'h000, 8'h06, 8'h10, 16'h0910, 16'h0001, 8'h02, 16'h0000, 16'h0000, 4'b0000, 8'h00);
        // Master times out and sends the same commit again, clean and to address 05
        req(9'h000, 8'h05, 8'h10, 16'h0910, 16'h0001, 8'h02, 16'h0000, 16'h0000, 4'b1010, 8'h00);
        $display("test silence done");
        test_done();
    end

    // Whole run is well under two hundred cycles; the 6000-cycle limit leaves a wide margin
    initial begin
        #(40 * 6000);
        errors++;
        test_done();
    end
endmodule : tb_top

`default_nettype wire

// ===== verilog/sslch_core.sv
// Overview of operation
// - Operation bit 0 is run/stop; bit 1 selects reverse or forward.
// - Operation bit 4 is external fault; bit 5 requests fault reset.
// - Operation bits C to F drive four contact inputs; others unused.
// - Bits a broadcast leaves undefined keep following local signal values.
// - Parameter writes go to staging; take effect only after commit.
// - Zero to 0900H commits and stores non-volatile; 0910H commits RAM only.
// - Reading a commit register answers invalid-register error 02H.
// - Function codes other than 03H, 08H, 10H answer error 01H.
// - Unmapped address or broadcast start outside 0000H-0002H gives 02H.
// - Quantity outside 1..16 or byte count not twice quantity gives 03H.
// - Out-of-limit or invalid written value answers error 21H.
// - Write-mode error 22H: running, read-only, or non-volatile fault.
// - Parameter or commit writes during undervoltage answer error 23H.
// - Parameter write while parameters still processing answers 24H.
// - Slave address zero: execute the write, send no reply.
// - Overrun, framing, parity or CRC error: ignore, no reply.
// - Slave address not ours: ignore, no reply.
// - Gap over 24 bit times or invalid length: stay silent.
// - Test-mode strap at power-up: loop data back, check, show pass.
// - Self-test failure: comm alarm, error contact on, ready off.
`timescale 1ns/1ps
`default_nettype none
`include "sslch_defines.svh"

module sslch_core
    import sslch_pkg::*;
#(
    parameter int DIAG_TIMEOUT_CYC = `SSLCH_DIAG_TIMEOUT_US * `SSLCH_CORE_CLK_MHZ
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] own_addr,
    input wire logic req_valid,
    input wire logic req_comm_err,
    input wire logic req_gap_err,
    input wire logic req_len_err,
    input wire logic [7:0] req_slave,
    input wire logic [7:0] req_func,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_qty,
    input wire logic [7:0] req_bytes,
    input wire logic [15:0] req_word0,
    input wire logic [15:0] req_word1,
    input wire logic param_limit_err,
    input wire logic param_permitted,
    input wire logic param_busy,
    input wire logic running,
    input wire logic main_undervoltage_alarm,
    input wire logic nonvolatile_fault_warning,
    input wire logic [15:0] local_op,
    input wire logic [7:0] input_five_function_select,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    output logic resp_valid,
    output logic resp_exception,
    output logic [7:0] resp_code,
    output logic [15:0] op_signal,
    output logic [15:0] freq_ref,
    output logic stage_we,
    output logic [15:0] stage_addr,
    output logic [15:0] stage_data,
    output logic commit_ram,
    output logic commit_nv,
    output logic loop_en,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic diag_pass,
    output logic comm_error_alarm,
    output logic error_contact,
    output logic op_ready
);

    ////////////////////////////////////////////////////////////////////////
    // Request decode
    logic bcast, mine, silent, is_rd, is_wr, is_loop;
    logic [15:0] last_addr;
    logic in_ctl, in_mon, in_par, is_cnv, is_cram, is_commit, mapped;
    logic [7:0] err;

    always_comb begin
        bcast = (req_slave == `SSLCH_BCAST_ADDR);
        mine = (req_slave == own_addr) || bcast;
        silent = req_comm_err || req_gap_err || req_len_err || !mine;
        is_rd = (req_func == `SSLCH_FN_READ);
        is_wr = (req_func == `SSLCH_FN_WRITE);
        is_loop = (req_func == `SSLCH_FN_LOOP);
        last_addr = req_addr + req_qty - `SSLCH_QTY_MIN;
        in_ctl = (req_addr <= `SSLCH_REG_FREQ) && (last_addr <= `SSLCH_REG_FREQ);
        in_mon = (req_addr >= `SSLCH_REG_MON_LO) && (last_addr <= `SSLCH_REG_MON_HI);
        in_par = (req_addr >= `SSLCH_REG_PAR_LO) && (last_addr <= `SSLCH_REG_PAR_HI);
        is_cnv = (req_addr == `SSLCH_REG_COMMIT_NV) && (req_qty == `SSLCH_QTY_MIN);
        is_cram = (req_addr == `SSLCH_REG_COMMIT_RAM) && (req_qty == `SSLCH_QTY_MIN);
        is_commit = is_cnv || is_cram;
        mapped = in_ctl || in_mon || in_par || (is_commit && is_wr);
        err = `SSLCH_ERR_NONE;
        if (!(is_rd || is_wr || is_loop)) begin
            err = `SSLCH_ERR_FUNC;
        end else if (is_loop) begin
            err = `SSLCH_ERR_NONE;
        end else if (req_qty < `SSLCH_QTY_MIN || req_qty > `SSLCH_QTY_MAX) begin
            err = `SSLCH_ERR_QTY;
        end else if (!mapped || (bcast && !in_ctl)) begin
            err = `SSLCH_ERR_REG;
        end else if (is_wr && ({8'h00, req_bytes} != {req_qty[14:0], 1'b0})) begin
            err = `SSLCH_ERR_QTY;
        end else if (is_wr && (in_mon || (running && (in_par || is_commit))
                || (nonvolatile_fault_warning && in_par && !param_permitted))) begin
            err = `SSLCH_ERR_MODE;
        end else if (is_wr && main_undervoltage_alarm && (in_par || is_commit)) begin
            err = `SSLCH_ERR_UV;
        end else if (is_wr && param_busy && in_par) begin
            err = `SSLCH_ERR_BUSY;
        end else if (is_wr && ((in_par && param_limit_err) || (is_commit && req_word0 != `SSLCH_REG_ZERO)
                || (in_ctl && req_addr == `SSLCH_REG_FREQ && req_word0 > `SSLCH_FREQ_FULL)
                || (in_ctl && req_addr == `SSLCH_REG_OP && req_qty > `SSLCH_QTY_MIN
                    && req_word1 > `SSLCH_FREQ_FULL))) begin
            err = `SSLCH_ERR_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and responses
    logic [15:0] op_q, op_d, freq_q, freq_d, op_out_q, op_out_d;
    logic resp_valid_q, resp_valid_d, resp_exc_q, resp_exc_d;
    logic [7:0] resp_code_q, resp_code_d;
    logic stage_we_q, stage_we_d, commit_ram_q, commit_ram_d, commit_nv_q, commit_nv_d;
    logic [15:0] stage_addr_q, stage_addr_d, stage_data_q, stage_data_d;
    logic do_wr;

    always_comb begin
        do_wr = req_valid && !silent && is_wr && (err == `SSLCH_ERR_NONE);
        op_d = op_q;
        freq_d = freq_q;
        if (do_wr && in_ctl) begin
            if (req_addr == `SSLCH_REG_OP) begin
                op_d = req_word0;
                if (req_qty > `SSLCH_QTY_MIN) begin
                    freq_d = req_word1;
                end
            end else if (req_addr == `SSLCH_REG_FREQ) begin
                freq_d = req_word0;
            end else if (req_qty > `SSLCH_QTY_MIN) begin
                op_d = req_word1;
                if (req_qty > 16'h0002) begin
                    freq_d = freq_q;
                end
            end
        end
        // Defined bits from the link, the rest straight from local sources
        op_out_d = (op_q & `SSLCH_OP_DEF_MASK) | (local_op & ~`SSLCH_OP_DEF_MASK);
        resp_valid_d = req_valid && !silent && !bcast;
        resp_exc_d = err != `SSLCH_ERR_NONE;
        resp_code_d = err;
        stage_we_d = do_wr && in_par;
        stage_addr_d = do_wr && in_par ? req_addr : stage_addr_q;
        stage_data_d = do_wr && in_par ? req_word0 : stage_data_q;
        commit_nv_d = do_wr && is_cnv;
        commit_ram_d = do_wr && is_cram;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            op_q <= `SSLCH_OP_RESET;
            freq_q <= `SSLCH_FREQ_RESET;
            op_out_q <= `SSLCH_OP_RESET;
            resp_valid_q <= 1'b0;
            resp_exc_q <= 1'b0;
            resp_code_q <= `SSLCH_ERR_NONE;
            stage_we_q <= 1'b0;
            stage_addr_q <= `SSLCH_REG_ZERO;
            stage_data_q <= `SSLCH_REG_ZERO;
            commit_nv_q <= 1'b0;
            commit_ram_q <= 1'b0;
        end else begin
            op_q <= op_d;
            freq_q <= freq_d;
            op_out_q <= op_out_d;
            resp_valid_q <= resp_valid_d;
            resp_exc_q <= resp_exc_d;
            resp_code_q <= resp_code_d;
            stage_we_q <= stage_we_d;
            stage_addr_q <= stage_addr_d;
            stage_data_q <= stage_data_d;
            commit_nv_q <= commit_nv_d;
            commit_ram_q <= commit_ram_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-up loopback self-diagnosis
    sslch_diag_t diag_q, diag_d;
    logic [2:0] dcnt_q, dcnt_d;
    logic [7:0] pat_q, pat_d;
    logic [15:0] tmo_q, tmo_d;
    logic tx_valid_q, tx_valid_d;
    logic loop_q, loop_d, pass_q, pass_d, fail_q, fail_d, ready_q, ready_d;

    always_comb begin
        diag_d = diag_q;
        dcnt_d = dcnt_q;
        pat_d = pat_q;
        tmo_d = tmo_q;
        tx_valid_d = 1'b0;
        unique case (diag_q)
            SSLCH_DIAG_STRAP: begin
                // Strap is read once, after reset release, never during it
                diag_d = (input_five_function_select == `SSLCH_DIAG_SEL) ? SSLCH_DIAG_SEND
                                                                         : SSLCH_DIAG_OFF;
            end
            SSLCH_DIAG_SEND: begin
                tx_valid_d = 1'b1;
                tmo_d = 16'h0000;
                diag_d = SSLCH_DIAG_WAIT;
            end
            SSLCH_DIAG_WAIT: begin
                tmo_d = tmo_q + 16'h0001;
                if (rx_valid) begin
                    if (rx_byte != pat_q) begin
                        diag_d = SSLCH_DIAG_FAIL;
                    end else if (dcnt_q == `SSLCH_DIAG_BYTES - 3'h1) begin
                        diag_d = SSLCH_DIAG_PASS;
                    end else begin
                        dcnt_d = dcnt_q + 3'h1;
                        pat_d = ~pat_q;
                        diag_d = SSLCH_DIAG_SEND;
                    end
                end else if (tmo_q >= DIAG_TIMEOUT_CYC[15:0] - 16'h0001) begin
                    diag_d = SSLCH_DIAG_FAIL;
                end
            end
            SSLCH_DIAG_PASS, SSLCH_DIAG_FAIL, SSLCH_DIAG_OFF: begin
                diag_d = diag_q;
            end
        endcase
        // Status taken from next state, so flopped outputs line up with the state
        loop_d = (diag_d == SSLCH_DIAG_SEND) || (diag_d == SSLCH_DIAG_WAIT);
        pass_d = (diag_d == SSLCH_DIAG_PASS);
        fail_d = (diag_d == SSLCH_DIAG_FAIL);
        ready_d = (diag_d == SSLCH_DIAG_PASS) || (diag_d == SSLCH_DIAG_OFF);
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            diag_q <= SSLCH_DIAG_STRAP;
            dcnt_q <= 3'h0;
            pat_q <= `SSLCH_DIAG_SEED;
            tmo_q <= 16'h0000;
            tx_valid_q <= 1'b0;
            loop_q <= 1'b0;
            pass_q <= 1'b0;
            fail_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            diag_q <= diag_d;
            dcnt_q <= dcnt_d;
            pat_q <= pat_d;
            tmo_q <= tmo_d;
            tx_valid_q <= tx_valid_d;
            loop_q <= loop_d;
            pass_q <= pass_d;
            fail_q <= fail_d;
            ready_q <= ready_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign resp_valid = resp_valid_q;
    assign resp_exception = resp_exc_q;
    assign resp_code = resp_code_q;
    assign op_signal = op_out_q;
    assign freq_ref = freq_q;
    assign stage_we = stage_we_q;
    assign stage_addr = stage_addr_q;
    assign stage_data = stage_data_q;
    assign commit_ram = commit_ram_q;
    assign commit_nv = commit_nv_q;
    assign tx_valid = tx_valid_q;
    assign tx_byte = pat_q;
    assign loop_en = loop_q;
    assign diag_pass = pass_q;
    assign comm_error_alarm = fail_q;
    assign error_contact = fail_q;
    assign op_ready = ready_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    bcast_no_reply_a: assert property (req_valid && bcast |=> !resp_valid)
        else $error("reply sent to broadcast");
    bad_frame_silent_a: assert property (req_valid && (req_comm_err || req_gap_err || req_len_err)
            |=> !resp_valid && !stage_we && !commit_nv && !commit_ram)
        else $error("errored frame was acted on");
    other_slave_a: assert property (req_valid && req_slave != own_addr && !bcast |=> !resp_valid)
        else $error("reply to foreign address");
    func_err_a: assert property (req_valid && !silent && !bcast && !(is_rd || is_wr || is_loop)
            |=> resp_valid && resp_exception && resp_code == `SSLCH_ERR_FUNC)
        else $error("bad function not answered 01");
    commit_read_a: assert property (req_valid && !silent && !bcast && is_rd && is_commit
            && req_qty == `SSLCH_QTY_MIN |=> resp_code == `SSLCH_ERR_REG)
        else $error("commit read not answered 02");
    uv_block_a: assert property (req_valid && main_undervoltage_alarm && (is_commit || in_par)
            |=> !commit_nv && !commit_ram && !stage_we)
        else $error("write acted on during undervoltage");
    running_block_a: assert property (req_valid && running && is_commit |=> !commit_nv && !commit_ram)
        else $error("commit executed while running");
    local_bits_a: assert property (1'b1 |=> (op_signal & ~`SSLCH_OP_DEF_MASK)
            == ($past(local_op) & ~`SSLCH_OP_DEF_MASK))
        else $error("undefined operation bits not from local source");
    diag_fail_a: assert property (diag_q == SSLCH_DIAG_WAIT && rx_valid && rx_byte != pat_q
            |=> ##1 comm_error_alarm && error_contact && !op_ready)
        else $error("self-test failure not signalled");
    freq_limit_a: assert property (1'b1 |-> freq_ref <= `SSLCH_FREQ_FULL)
        else $error("frequency reference above full scale");

endmodule : sslch_core

`default_nettype wire

// ===== verilog/sslch_defines.svh
`ifndef SSLCH_DEFINES_SVH
`define SSLCH_DEFINES_SVH

// Function codes
`define SSLCH_FN_READ 8'h03
`define SSLCH_FN_LOOP 8'h08
`define SSLCH_FN_WRITE 8'h10

// Error codes
`define SSLCH_ERR_FUNC 8'h01
`define SSLCH_ERR_REG 8'h02
`define SSLCH_ERR_QTY 8'h03
`define SSLCH_ERR_DATA 8'h21
`define SSLCH_ERR_MODE 8'h22
`define SSLCH_ERR_UV 8'h23
`define SSLCH_ERR_BUSY 8'h24
`define SSLCH_ERR_NONE 8'h00

// Register map
`define SSLCH_BCAST_ADDR 8'h00
`define SSLCH_REG_ZERO 16'h0000
`define SSLCH_REG_OP 16'h0001
`define SSLCH_REG_FREQ 16'h0002
`define SSLCH_REG_MON_LO 16'h0020
`define SSLCH_REG_MON_HI 16'h003f
`define SSLCH_REG_PAR_LO 16'h0100
`define SSLCH_REG_PAR_HI 16'h08ff
`define SSLCH_REG_COMMIT_NV 16'h0900
`define SSLCH_REG_COMMIT_RAM 16'h0910

// Quantity limits
`define SSLCH_QTY_MIN 16'h0001
`define SSLCH_QTY_MAX 16'h0010

// Operation signal fields
`define SSLCH_OP_RUN 0
`define SSLCH_OP_REV 1
`define SSLCH_OP_EXTF 4
`define SSLCH_OP_FRST 5
`define SSLCH_OP_CONT_LO 12
`define SSLCH_OP_DEF_MASK 16'hf033
`define SSLCH_OP_RESET 16'h0000

// Frequency reference full scale (100 percent)
`define SSLCH_FREQ_FULL 16'h7530
`define SSLCH_FREQ_RESET 16'h0000

// Self-diagnosis
`define SSLCH_DIAG_SEL 8'h43
`define SSLCH_DIAG_SEED 8'h55
`define SSLCH_DIAG_BYTES 3'h4
`define SSLCH_DIAG_TIMEOUT_US 1000
`define SSLCH_CORE_CLK_MHZ 25

`endif

// ===== verilog/sslch_pkg.sv
package sslch_pkg;
    typedef enum logic [2:0] {
        SSLCH_DIAG_STRAP,
        SSLCH_DIAG_SEND,
        SSLCH_DIAG_WAIT,
        SSLCH_DIAG_PASS,
        SSLCH_DIAG_FAIL,
        SSLCH_DIAG_OFF
    } sslch_diag_t;
endpackage : sslch_pkg
